// *** mfe_pkg.sv ***
/*
 * Constants shared by the MII receive front end: delimiter, CRC and frame limits.
 * Assumes nibble counts, where one MII nibble stands for four bit times.
 */
package mfe_pkg;
	localparam int unsigned PORT_COUNT = 24;
	localparam int unsigned REVERSIBLE_PORTS = 10;
	localparam int unsigned LOOKUP_ENTRIES = 2000;
	localparam logic [7:0] SFD_BYTE = 8'hd5;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
	localparam int unsigned BITS_PER_NIBBLE = 4;
	localparam int unsigned MIN_IFG_BT = 80;
	localparam int unsigned SHORT_EVENT_BT = 76;
	localparam int unsigned RUNT_BYTES = 64;
	localparam int unsigned LONG_BYTES = 1518;
	localparam int unsigned JABBER_BT = 50000;
	localparam logic [4:0] IFG_NIBBLES = 5'(MIN_IFG_BT / BITS_PER_NIBBLE);
	localparam logic [13:0] SHORT_NIBBLES = 14'((SHORT_EVENT_BT + 3) / BITS_PER_NIBBLE);
	localparam logic [13:0] RUNT_NIBBLES = 14'(RUNT_BYTES * 2);
	localparam logic [13:0] LONG_NIBBLES = 14'(LONG_BYTES * 2);
	localparam int unsigned JABBER_NIBBLES = JABBER_BT / BITS_PER_NIBBLE;
	localparam int unsigned DA_BYTES = 6;
	localparam int unsigned SA_END_BYTE = 12;
endpackage : mfe_pkg

// *** mfe_rx_front_end.sv ***
/*
 * Receive front end of one switch port: MII nibbles in, screened bytes and addresses out.
 * Assumes the MII pins are asynchronous to clk_i and the receive clock is well below clk_i/4.
 */
`timescale 1ns/1ps

module mfe_rx_front_end #(
	parameter int unsigned PORT_ID = 0,
	parameter int unsigned JABBER_LIMIT = mfe_pkg::JABBER_NIBBLES
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// MII receive pins.
	input wire logic mii_rx_clk_i,
	input wire logic [3:0] mii_rxd_i,
	input wire logic mii_rx_dv_i,
	input wire logic mii_rx_er_i,
	// Port configuration.
	input wire logic port_reversed_i,
	output logic port_reversed_o,
	// Byte stream towards the switch buffer.
	output logic [7:0] out_data_o,
	output logic out_last_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	// Frame verdict.
	output logic frame_ok_o,
	output logic frame_err_o,
	// Lookup engine request and source learning.
	output logic [47:0] da_o,
	output logic da_valid_o,
	output logic da_multicast_o,
	output logic [47:0] sa_o,
	output logic sa_learn_o
);

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HUNT = 4'h2,
		ST_RECV = 4'h4,
		ST_DROP = 4'h8
	} mfe_state_type;

	typedef struct packed {
		logic ck1, ck2, ck3;
		logic [3:0] d1, d2;
		logic dv1, dv2, er1, er2;
		mfe_state_type st;
		logic [7:0] sr;
		logic [3:0] lo;
		logic [13:0] nib;
		logic [13:0] car;
		logic [4:0] ifg;
		logic [31:0] crc;
		logic err;
		logic [7:0] pend;
		logic pend_v;
		logic [8:0] hd, tl;
		logic hv, tv;
		logic [47:0] da, sa;
		logic da_v, mc, learn, ok, bad, rev;
	} mfe_regs_type;

	mfe_regs_type s, next_s;

	// Four CRC steps per nibble, earliest bit in bit 0.
	function automatic logic [31:0] mfe_crc_nib(input logic [31:0] c, input logic [3:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ mfe_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : mfe_crc_nib

	function automatic logic [13:0] mfe_sat_inc(input logic [13:0] v);
		return (v == 14'h3fff) ? v : v + 14'h0001;
	endfunction : mfe_sat_inc

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic fall, room, push, last_bad, dv, er;
		logic [3:0] d;
		logic [7:0] b;
		logic [8:0] pword;
		logic [12:0] idx;
		fall = 1'b0;
		room = 1'b0;
		push = 1'b0;
		last_bad = 1'b0;
		dv = 1'b0;
		er = 1'b0;
		d = 4'h0;
		b = 8'h00;
		pword = 9'h000;
		idx = 13'h0000;
		next_s = s;
		next_s.ck1 = mii_rx_clk_i;
		next_s.ck2 = s.ck1;
		next_s.ck3 = s.ck2;
		next_s.d1 = mii_rxd_i;
		next_s.d2 = s.d1;
		next_s.dv1 = mii_rx_dv_i;
		next_s.dv2 = s.dv1;
		next_s.er1 = mii_rx_er_i;
		next_s.er2 = s.er1;
		next_s.da_v = 1'b0;
		next_s.learn = 1'b0;
		next_s.ok = 1'b0;
		next_s.bad = 1'b0;
		next_s.rev = port_reversed_i && (PORT_ID < mfe_pkg::REVERSIBLE_PORTS);
		// Buffer drain side: head leaves, tail moves up.
		if (out_ready_i && s.hv) begin
			next_s.hv = s.tv;
			next_s.hd = s.tl;
			next_s.tv = 1'b0;
		end
		room = !(next_s.hv && next_s.tv);
		// Nibbles are taken on the falling edge, mid-way in the PHY's stable window.
		fall = s.ck3 && !s.ck2;
		dv = s.dv2;
		er = s.er2;
		d = s.d2;
		if (fall) begin
			if (dv) begin
				// Counting in nibbles keeps every limit the same at 10 and 100 Mbps.
				next_s.car = mfe_sat_inc(s.car);
			end else if (s.ifg != 5'h1f) begin
				next_s.ifg = s.ifg + 5'h01;
			end
			unique case (s.st)
				ST_IDLE: begin
					if (dv) begin
						next_s.car = 14'h0001;
						next_s.sr = {d, 4'h0};
						next_s.st = (s.ifg < mfe_pkg::IFG_NIBBLES) ? ST_DROP : ST_HUNT;
						if (er) begin
							next_s.st = ST_DROP;
						end
					end
				end
				ST_HUNT: begin
					next_s.sr = {d, s.sr[7:4]};
					if (!dv) begin
						next_s.st = ST_IDLE;
						next_s.ifg = 5'h00;
					end else if (er) begin
						next_s.st = ST_DROP;
					end else if ({d, s.sr[7:4]} == mfe_pkg::SFD_BYTE) begin
						next_s.st = ST_RECV;
						next_s.crc = mfe_pkg::CRC_INIT;
						next_s.nib = 14'h0000;
						next_s.err = 1'b0;
						next_s.pend_v = 1'b0;
					end
				end
				ST_RECV: begin
					if (dv) begin
						next_s.nib = mfe_sat_inc(s.nib);
						next_s.crc = mfe_crc_nib(s.crc, d);
						if (er || s.car >= 14'(JABBER_LIMIT)) begin
							next_s.err = 1'b1;
						end
						if (s.nib[0]) begin
							b = {d, s.lo};
							idx = s.nib[13:1];
							if (idx < 13'(mfe_pkg::DA_BYTES)) begin
								next_s.da = {s.da[39:0], b};
								if (idx == 13'(mfe_pkg::DA_BYTES - 1)) begin
									next_s.da_v = 1'b1;
									// Before the last shift the first byte still sits in bits 39:32.
									next_s.mc = s.da[32];
								end
							end else if (idx < 13'(mfe_pkg::SA_END_BYTE)) begin
								next_s.sa = {s.sa[39:0], b};
							end
							// One byte is held back so the final byte can carry the end mark.
							if (s.pend_v) begin
								push = 1'b1;
								pword = {1'b0, s.pend};
							end
							next_s.pend = b;
							next_s.pend_v = 1'b1;
						end else begin
							next_s.lo = d;
						end
					end else begin
						last_bad = s.err || s.nib[0]
							|| s.crc != mfe_pkg::CRC_RESIDUE
							|| s.car < mfe_pkg::SHORT_NIBBLES
							|| s.nib < mfe_pkg::RUNT_NIBBLES
							|| s.nib > mfe_pkg::LONG_NIBBLES
							|| (s.pend_v && !room);
						if (s.pend_v) begin
							push = 1'b1;
							pword = {1'b1, s.pend};
						end
						next_s.pend_v = 1'b0;
						next_s.ok = !last_bad;
						next_s.bad = last_bad;
						next_s.learn = !last_bad;
						next_s.st = ST_IDLE;
						next_s.ifg = 5'h00;
					end
				end
				ST_DROP: begin
					if (!dv) begin
						next_s.st = ST_IDLE;
						next_s.ifg = 5'h00;
					end
				end
			endcase
		end
		// Filling side: a byte that finds both entries taken marks the frame bad.
		if (push) begin
			if (!room) begin
				next_s.err = 1'b1;
			end else if (!next_s.hv) begin
				next_s.hd = pword;
				next_s.hv = 1'b1;
			end else begin
				next_s.tl = pword;
				next_s.tv = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.ifg <= 5'h1f;
			s.crc <= mfe_pkg::CRC_INIT;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign port_reversed_o = s.rev;
	assign out_data_o = s.hd[7:0];
	assign out_last_o = s.hd[8];
	assign out_valid_o = s.hv;
	assign frame_ok_o = s.ok;
	assign frame_err_o = s.bad;
	assign da_o = s.da;
	assign da_valid_o = s.da_v;
	assign da_multicast_o = s.mc;
	assign sa_o = s.sa;
	assign sa_learn_o = s.learn;

endmodule : mfe_rx_front_end

// *** mfe_rx_monitor.sv ***
/* Port checker for the receive front end.
 * Assumes it is bound to every front end. */
`timescale 1ns/1ps
module mfe_rx_monitor #(
	parameter int unsigned PORT_ID = 0
) (
	// Watched ports.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic port_reversed_i,
	input wire logic port_reversed_o,
	input wire logic [7:0] out_data_o,
	input wire logic out_last_o,
	input wire logic out_valid_o,
	input wire logic out_ready_i,
	input wire logic frame_ok_o,
	input wire logic frame_err_o,
	input wire logic [47:0] da_o,
	input wire logic da_valid_o,
	input wire logic da_multicast_o,
	input wire logic sa_learn_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_stall;
		out_valid_o && !out_ready_i;
	endsequence
	a_head_holds: assert property (s_stall |=> out_valid_o && $stable({out_data_o, out_last_o}))
		else $error("head moved");
	a_learn_ok: assert property (sa_learn_o |-> frame_ok_o) else $error("bad learn");
	a_ok_learns: assert property (frame_ok_o |-> sa_learn_o) else $error("ok no learn");
	a_err_quiet: assert property (frame_err_o |-> !sa_learn_o && !frame_ok_o)
		else $error("err with ok");
	a_ok_pulse: assert property (frame_ok_o |=> !frame_ok_o) else $error("ok long");
	a_err_pulse: assert property (frame_err_o |=> !frame_err_o) else $error("err long");
	a_da_pulse: assert property (da_valid_o |=> !da_valid_o [*8]) else $error("da pulse");
	a_mcast_bit: assert property (da_valid_o |-> da_multicast_o == da_o[40])
		else $error("mcast bit");
	a_rev_port: assert property ($past(!rst_i) |->
		port_reversed_o == ($past(port_reversed_i) && PORT_ID < 10)) else $error("rev");
endmodule : mfe_rx_monitor
bind mfe_rx_front_end mfe_rx_monitor #(.PORT_ID(PORT_ID)) mfe_rx_monitor_inst (
	.clk_i(clk_i), .rst_i(rst_i), .port_reversed_i(port_reversed_i),
	.port_reversed_o(port_reversed_o), .out_data_o(out_data_o), .out_last_o(out_last_o),
	.out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .frame_ok_o(frame_ok_o),
	.frame_err_o(frame_err_o), .da_o(da_o), .da_valid_o(da_valid_o),
	.da_multicast_o(da_multicast_o), .sa_learn_o(sa_learn_o));

// *** mfe_phy_model.sv ***
/* PHY side of the MII receive path.
 * Assumes the bench calls send once per frame. */
`timescale 1ns/1ps
module mfe_phy_model (
	// MII receive pins.
	output logic rx_clk_o,
	output logic [3:0] rxd_o,
	output logic dv_o,
	output logic er_o
);
	initial begin
		rx_clk_o = 1'b0;
		rxd_o = 4'h0;
		dv_o = 1'b0;
		er_o = 1'b0;
	end
	// Lines change on the rising edge; idle data is inverted every nibble.
	task automatic nib(input logic [3:0] n, input logic v, input logic e);
		#16 rx_clk_o = 1'b1;
		rxd_o = v ? n : ~rxd_o;
		dv_o = v;
		er_o = e;
		#16 rx_clk_o = 1'b0;
	endtask : nib
	task automatic send(input logic [7:0] b[$], input int pre, gap, er_at);
		repeat (gap) nib(4'h0, 1'b0, 1'b0);
		repeat (pre) nib(4'h5, 1'b1, 1'b0);
		nib(4'h5, 1'b1, 1'b0);
		nib(4'hd, 1'b1, 1'b0);
		foreach (b[i]) begin
			nib(b[i][3:0], 1'b1, i == er_at);
			nib(b[i][7:4], 1'b1, 1'b0);
		end
		repeat (3) nib(4'h0, 1'b0, 1'b0);
	endtask : send
endmodule : mfe_phy_model

// *** testbench.sv ***
/* Self-checking bench for one receive front end.
 * Assumes the PHY model and the bound checker. */
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ready = 1'b0;
	logic rev_i = 1'b0;
	logic hold = 1'b0;
	logic rxc, dv, er, rev_o, last, valid, ok, err, dav, mc, lrn;
	logic [3:0] rxd;
	logic [7:0] data;
	logic [47:0] da, sa;
	logic [7:0] fr[$];
	logic [8:0] got[$];
	int bad_count = 0, check_count = 0, n_ok, n_err, n_dav, n_lrn, cyc = 0;
	always #2 clk_i = ~clk_i;
	mfe_phy_model mfe_phy_model_inst (.rx_clk_o(rxc), .rxd_o(rxd), .dv_o(dv), .er_o(er));
	mfe_rx_front_end #(.PORT_ID(3), .JABBER_LIMIT(4000)) mfe_rx_front_end_inst (
		.clk_i(clk_i), .rst_i(rst_i), .mii_rx_clk_i(rxc), .mii_rxd_i(rxd),
		.mii_rx_dv_i(dv), .mii_rx_er_i(er), .port_reversed_i(rev_i),
		.port_reversed_o(rev_o), .out_data_o(data), .out_last_o(last),
		.out_valid_o(valid), .out_ready_i(ready), .frame_ok_o(ok), .frame_err_o(err),
		.da_o(da), .da_valid_o(dav), .da_multicast_o(mc), .sa_o(sa), .sa_learn_o(lrn));
	// The consumer stalls one cycle in four, or wholly while hold is set.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		ready <= !hold && cyc[1:0] != 2'h0;
		if (valid && ready)
			got.push_back({last, data});
		n_ok <= n_ok + ok;
		n_err <= n_err + err;
		n_dav <= n_dav + dav;
		n_lrn <= n_lrn + lrn;
	end
	task automatic chk(input logic [47:0] seen, want);
		check_count++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////
	task automatic build(input int len, input logic [7:0] d0, input logic bad);
		logic [31:0] c;
		fr = {};
		c = mfe_pkg::CRC_INIT;
		for (int i = 0; i < len; i++)
			fr.push_back(i < 12 ? d0 + 8'(i) : 8'(i * 7));
		foreach (fr[i])
			for (int b = 0; b < 8; b++)
				c = (c >> 1) ^ ((c[0] ^ fr[i][b]) ? mfe_pkg::CRC_POLY : 32'h0);
		c = ~c ^ {31'h0, bad};
		for (int i = 0; i < 4; i++)
			fr.push_back(c[8*i+:8]);
	endtask : build
	function automatic logic [47:0] addr(input int s);
		for (int i = 0; i < 6; i++)
			addr = {addr[39:0], fr[s+i]};
	endfunction : addr
	// Sends the frame, drains the buffer, then compares pulse counts.
	task automatic run(input int pre, gap, er_at, input logic stall, input logic [15:0] want);
		@(negedge clk_i);
		got = {};
		n_ok = 0;
		n_err = 0;
		n_dav = 0;
		n_lrn = 0;
		hold = stall;
		mfe_phy_model_inst.send(fr, pre, gap, er_at);
		hold = 1'b0;
		for (int i = 0; valid; i++) begin
			if (i == 300) begin
				bad_count++;
				stop_test();
			end
			@(posedge clk_i);
		end
		chk({n_ok[3:0], n_err[3:0], n_lrn[3:0], n_dav[3:0]}, 48'(want));
	endtask : run
	////////////////////////////////////////////////////////////////////////
	task automatic s_good;
		build(60, 8'h02, 1'b0);
		run(15, 20, -1, 1'b0, 16'h1011);
		chk(got.size(), 64);
		foreach (got[i])
			chk(got[i], {i == 63, fr[i]});
		chk(da, addr(0));
		chk(mc, 1'b0);
		chk(sa, addr(6));
	endtask : s_good
	task automatic s_crc_mcast;
		build(60, 8'h01, 1'b1);
		run(0, 20, -1, 1'b0, 16'h0101);
		chk(mc, 1'b1);
	endtask : s_crc_mcast
	task automatic s_faults;
		build(60, 8'h02, 1'b0);
		run(8, 2, -1, 1'b0, 16'h0000);
		chk(got.size(), 0);
		run(8, 20, 20, 1'b0, 16'h0101);
		run(8, 20, -1, 1'b1, 16'h0101);
		chk(got.size(), 2);
		build(40, 8'h02, 1'b0);
		run(8, 20, -1, 1'b0, 16'h0101);
		build(4, 8'h02, 1'b0);
		run(0, 20, -1, 1'b0, 16'h0101);
	endtask : s_faults
	task automatic s_rev;
		rev_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(rev_o, 1'b1);
	endtask : s_rev
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		s_good();
		s_crc_mcast();
		s_faults();
		s_rev();
		stop_test();
	end
endmodule : testbench
